// ---- core/pxb_pkg.sv ----
// Purpose: Constants for the port I/O crossbar block
// Assumes: 18 pins, pins 0..15 crossbar capable, 16..17 plain GPIO
// Notes:   Byte offsets are word aligned on the AHB-Lite slave
package pxb_pkg;
    // Pin and slot geometry
    localparam int PIN_N   = 18;
    localparam int XB_N    = 16;
    localparam int SLOT_N  = 20;
    localparam int OWN_W   = 5;
    localparam logic [4:0] OWN_NONE = 5'h1f;

    // Register byte offsets
    localparam logic [7:0] REG_MDIN  = 8'h00;
    localparam logic [7:0] REG_MDOUT = 8'h04;
    localparam logic [7:0] REG_SKIP  = 8'h08;
    localparam logic [7:0] REG_LATCH = 8'h0c;
    localparam logic [7:0] REG_SEL_A = 8'h10;
    localparam logic [7:0] REG_SEL_B = 8'h14;
    localparam logic [7:0] REG_SEL_C = 8'h18;
    localparam logic [7:0] REG_DRV   = 8'h1c;
    localparam logic [7:0] REG_EXTI  = 8'h20;

    // Reset values
    localparam logic [17:0] RST_MDIN  = 18'h3ffff;
    localparam logic [17:0] RST_MDOUT = 18'h00000;
    localparam logic [15:0] RST_SKIP  = 16'h0000;
    localparam logic [17:0] RST_LATCH = 18'h3ffff;
    localparam logic [7:0]  RST_SEL   = 8'h00;
    localparam logic [2:0]  RST_DRV   = 3'h7;
    localparam logic [7:0]  RST_EXTI  = 8'h00;

    // Select register A fields
    localparam int SA_UART = 0;
    localparam int SA_SPI  = 1;
    localparam int SA_SMB  = 2;
    localparam int SA_CP0  = 3;
    localparam int SA_CP0A = 4;
    localparam int SA_CP1  = 5;
    localparam int SA_CP1A = 6;
    localparam int SA_SCLK = 7;
    // Select register B fields
    localparam int SB_CEX  = 0;
    localparam int SB_ECI  = 2;
    localparam int SB_T0   = 3;
    localparam int SB_T1   = 4;
    localparam int SB_T2   = 5;
    localparam int SB_WPUD = 7;
    // Select register C and external event fields
    localparam int SC_CROSSBAR_ENABLE_BIT = 0;
    localparam int EI0_LSB  = 0;
    localparam int EI1_LSB  = 4;

    // Resource slots in priority order
    localparam int SL_UTX  = 0;
    localparam int SL_URX  = 1;
    localparam int SL_SPI  = 2;
    localparam int SL_SDA  = 6;
    localparam int SL_SCL  = 7;
    localparam int SL_CP0  = 8;
    localparam int SL_CEX  = 13;
    localparam int SL_ECI  = 16;
    localparam int SL_TMR  = 17;

    // Fixed pin positions
    localparam int PIN_UTX = 4;
    localparam int PIN_URX = 5;
    localparam int PIN_CLK = 3;
    localparam int PIN_CNV = 6;
    localparam int PIN_DBG = 16;
endpackage : pxb_pkg

// ---- core/pxb_port_io.sv ----
// Purpose: Port I/O pads, crossbar routing and AHB-Lite registers
// Assumes: Pad inputs are asynchronous; peripherals share hclk
// Notes:   Zero wait state slave; every pad control is registered
//
// Overview of operation
// - Input mode one is digital, zero is analog.
// - Reset leaves every pin digital.
// - Analog pins lose pull-up, driver and receiver, except that an active debug link still drives P2.0.
// - Output mode picks open-drain or push-pull, peripherals too.
// - Two-wire bus pins are always open-drain.
// - Open-drain pins get a pull-up unless globally disabled.
// - A pin driving zero loses its pull-up.
// - Crossbar off leaves crossbar pins as plain inputs.
// - Crossbar off disables all crossbar pin drivers.
// - Routing only to pins 0..15, with clear skip bits except for the serial unit.
// - Serial unit always on P0.4 and P0.5.
// - P2.0 and P2.1 are GPIO only.
// - P2.0 is shared with the debug data signal.
// - Latch reads return the pin states, with analog pins reading zero.
// - Fixed functions work on digital pins only.
// - Pin transitions raise events; interrupt pins chosen in P0.
// - Each bank has two drive strengths.
// - Each resource but the serial unit takes the lowest free, unskipped pin.
`timescale 1ns/10ps
module pxb_port_io
    import pxb_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic [PIN_N-1:0]  pad_in,
    output logic [PIN_N-1:0]       pad_out,
    output logic [PIN_N-1:0]       pad_oe,
    output logic [PIN_N-1:0]       pad_pullup,
    output logic [PIN_N-1:0]       pad_rx_en,
    output logic [2:0]             pad_drive_high,
    input  wire logic [SLOT_N-1:0] per_out,
    input  wire logic [SLOT_N-1:0] per_drv,
    output logic [SLOT_N-1:0]      per_in,
    input  wire logic              dbg_active,
    input  wire logic              dbg_out,
    input  wire logic              dbg_oe,
    output logic                   dbg_in,
    output logic [1:0]             ext_int_lvl,
    output logic [1:0]             ext_int_edge,
    output logic                   conv_start,
    output logic                   ext_clk
);
    // Software registers
    logic [PIN_N-1:0]      mdin_ff;
    logic [PIN_N-1:0]      mdout_ff;
    logic [XB_N-1:0]       skip_ff;
    logic [PIN_N-1:0]      latch_ff;
    logic [7:0]            sel_a_ff;
    logic [7:0]            sel_b_ff;
    logic [7:0]            sel_c_ff;
    logic [2:0]            drv_ff;
    logic [7:0]            exti_ff;

    // Bus state
    logic                  wr_pend_ff;
    logic [7:0]            wr_addr_ff;
    logic [31:0]           hrdata_ff;
    logic                  hreadyout_ff;
    logic                  addr_ok;

    // Pin state
    logic [PIN_N-1:0]      pin_meta_ff;
    logic [PIN_N-1:0]      pin_sync_ff;
    logic [PIN_N-1:0]      pad_out_ff;
    logic [PIN_N-1:0]      pad_oe_ff;
    logic [PIN_N-1:0]      pad_pu_ff;
    logic [PIN_N-1:0]      pad_rx_ff;
    logic [PIN_N-1:0]      nxt_pad_out;
    logic [PIN_N-1:0]      nxt_pad_oe;
    logic [PIN_N-1:0]      nxt_pad_pu;
    logic [SLOT_N-1:0]     per_in_ff;
    logic [SLOT_N-1:0]     nxt_per_in;
    logic                  dbg_in_ff;
    logic [1:0]            ei_lvl_ff;
    logic [1:0]            ei_edge_ff;
    logic [1:0]            nxt_ei_lvl;
    logic                  conv_ff;
    logic                  eclk_ff;
    logic [XB_N*OWN_W-1:0] own_map;
    logic [SLOT_N-1:0]     slot_en;
    logic                  crossbar_enable_bit;
    logic                  wpud;

    // Expand the select registers into one enable per resource slot
    function automatic logic [SLOT_N-1:0] slots_of(
        input logic [7:0] a,
        input logic [7:0] b
    );
        logic [SLOT_N-1:0] e;
        logic [1:0]        cex;
        e   = '0;
        cex = b[SB_CEX +: 2];
        e[SL_UTX] = a[SA_UART];
        e[SL_URX] = a[SA_UART];
        e[SL_SPI +: 4] = {4{a[SA_SPI]}};
        e[SL_SDA] = a[SA_SMB];
        e[SL_SCL] = a[SA_SMB];
        e[SL_CP0 +: 5] = {a[SA_SCLK], a[SA_CP1A], a[SA_CP1],
                          a[SA_CP0A], a[SA_CP0]};
        e[SL_CEX] = (cex != 2'h0);
        e[SL_CEX + 1] = (cex > 2'h1);
        e[SL_CEX + 2] = (cex == 2'h3);
        e[SL_ECI] = b[SB_ECI];
        e[SL_TMR +: 3] = {b[SB_T2], b[SB_T1], b[SB_T0]};
        return e;
    endfunction : slots_of

    // Fixed-function pin level, forced low on analog pins
    function automatic logic fixed_lvl(
        input logic [PIN_N-1:0] pins,
        input logic [PIN_N-1:0] mdin,
        input int               idx
    );
        return pins[idx] & mdin[idx];
    endfunction : fixed_lvl

    // Read data decode for one byte offset
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            REG_MDIN:  d[PIN_N-1:0] = mdin_ff;
            REG_MDOUT: d[PIN_N-1:0] = mdout_ff;
            REG_SKIP:  d[XB_N-1:0]  = skip_ff;
            REG_LATCH: d[PIN_N-1:0] = pin_sync_ff & mdin_ff;
            REG_SEL_A: d[7:0]       = sel_a_ff;
            REG_SEL_B: d[7:0]       = sel_b_ff;
            REG_SEL_C: d[7:0]       = sel_c_ff;
            REG_DRV:   d[2:0]       = drv_ff;
            REG_EXTI:  d[7:0]       = exti_ff;
            default:   d            = 32'h0000_0000;
        endcase
        return d;
    endfunction : rd_word

    assign slot_en = slots_of(sel_a_ff, sel_b_ff);
    assign crossbar_enable_bit   = sel_c_ff[SC_CROSSBAR_ENABLE_BIT];
    assign wpud    = sel_b_ff[SB_WPUD];
    assign addr_ok = hsel & htrans[1] & hready;

    // Crossbar priority decoder
    pxb_xbar_map u_map (
        .hclk    (hclk),
        .hresetn (hresetn),
        .slot_en (slot_en),
        .skip    (skip_ff),
        .own_map (own_map)
    );

    // Address phase capture; writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff   <= 1'b0;
            wr_addr_ff   <= 8'h00;
            hrdata_ff    <= 32'h0000_0000;
            hreadyout_ff <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;                      // Never stalls
            wr_pend_ff   <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_ff <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata_ff <= rd_word(haddr[7:0]);
            end
        end
    end

    // Mode, skip and latch registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdin_ff  <= RST_MDIN;
            mdout_ff <= RST_MDOUT;
            skip_ff  <= RST_SKIP;
            latch_ff <= RST_LATCH;
        end else if (wr_pend_ff) begin
            unique case (wr_addr_ff)
                REG_MDIN:  mdin_ff  <= hwdata[PIN_N-1:0];
                REG_MDOUT: mdout_ff <= hwdata[PIN_N-1:0];
                REG_SKIP:  skip_ff  <= hwdata[XB_N-1:0];
                REG_LATCH: latch_ff <= hwdata[PIN_N-1:0];
                default:   ;
            endcase
        end
    end

    // Select, drive and event registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_a_ff <= RST_SEL;
            sel_b_ff <= RST_SEL;
            sel_c_ff <= RST_SEL;
            drv_ff   <= RST_DRV;
            exti_ff  <= RST_EXTI;
        end else if (wr_pend_ff) begin
            unique case (wr_addr_ff)
                REG_SEL_A: sel_a_ff <= hwdata[7:0];
                REG_SEL_B: sel_b_ff <= hwdata[7:0];
                REG_SEL_C: sel_c_ff <= hwdata[7:0];
                REG_DRV:   drv_ff   <= hwdata[2:0];
                REG_EXTI:  exti_ff  <= hwdata[7:0];
                default:   ;
            endcase
        end
    end

    // Two-stage synchroniser on every pad input
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            pin_meta_ff <= pad_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Per-pin drive decision
    always_comb begin
        logic [OWN_W-1:0] own;
        logic             xb;
        logic             use_per;
        logic             v;
        logic             drv;
        logic             od;
        logic             gate;
        own     = OWN_NONE;
        xb      = 1'b0;
        use_per = 1'b0;
        v       = 1'b1;
        drv     = 1'b0;
        od      = 1'b1;
        gate    = 1'b0;
        for (int i = 0; i < PIN_N; i++) begin
            xb  = (i < XB_N);
            own = xb ? own_map[i*OWN_W +: OWN_W] : OWN_NONE;
            use_per = xb && (own != OWN_NONE);
            // Routed peripheral or latch bit as data source
            v   = use_per ? per_out[own] : latch_ff[i];
            drv = use_per ? per_drv[own] : 1'b1;
            od  = !mdout_ff[i];
            if (use_per && (own == OWN_W'(SL_SDA) || own == OWN_W'(SL_SCL))) begin
                od = 1'b1;
            end
            // Crossbar off keeps crossbar pins as inputs only
            gate = mdin_ff[i] && (!xb || crossbar_enable_bit);
            if (i == PIN_DBG && dbg_active) begin
                v    = dbg_out;
                drv  = dbg_oe;
                od   = 1'b0;
                gate = 1'b1;
            end
            nxt_pad_out[i] = v;
            // Open-drain drives only a zero
            nxt_pad_oe[i]  = gate && drv && (!v || !od);
            // Pull-up on open-drain digital pins not driving low
            nxt_pad_pu[i]  = mdin_ff[i] && od && !wpud
                             && !(nxt_pad_oe[i] && !v);
        end
    end

    // Peripheral input return from the pin each slot owns
    always_comb begin
        logic [OWN_W-1:0] own;
        own        = OWN_NONE;
        nxt_per_in = '1;                               // Idle high if unrouted
        for (int i = 0; i < XB_N; i++) begin
            own = own_map[i*OWN_W +: OWN_W];
            if (own != OWN_NONE && crossbar_enable_bit) begin
                nxt_per_in[own] = pin_sync_ff[i] | !mdin_ff[i];
            end
        end
    end

    // Registered pad controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out_ff <= '1;
            pad_oe_ff  <= '0;
            pad_pu_ff  <= '1;
            pad_rx_ff  <= '1;
        end else begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_ff  <= nxt_pad_oe;
            pad_pu_ff  <= nxt_pad_pu;
            pad_rx_ff  <= mdin_ff;
        end
    end

    // Selected external interrupt pins in bank 0
    always_comb begin
        nxt_ei_lvl[0] = fixed_lvl(pin_sync_ff, mdin_ff,
                                  int'(exti_ff[EI0_LSB +: 3]));
        nxt_ei_lvl[1] = fixed_lvl(pin_sync_ff, mdin_ff,
                                  int'(exti_ff[EI1_LSB +: 3]));
    end

    // Fixed functions and transition events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ei_lvl_ff  <= 2'h0;
            ei_edge_ff <= 2'h0;
            conv_ff    <= 1'b0;
            eclk_ff    <= 1'b0;
            per_in_ff  <= '1;
            dbg_in_ff  <= 1'b0;
        end else begin
            ei_lvl_ff  <= nxt_ei_lvl;
            // One-cycle pulse on any transition of the chosen pin
            ei_edge_ff <= nxt_ei_lvl ^ ei_lvl_ff;
            conv_ff    <= fixed_lvl(pin_sync_ff, mdin_ff, PIN_CNV);
            eclk_ff    <= fixed_lvl(pin_sync_ff, mdin_ff, PIN_CLK);
            per_in_ff  <= nxt_per_in;
            // Debug port sees the pad even when it is analog
            dbg_in_ff  <= pin_sync_ff[PIN_DBG];
        end
    end

    // Port drivers
    assign hreadyout      = hreadyout_ff;
    assign hresp          = 1'b0;
    assign hrdata         = hrdata_ff;
    assign pad_out        = pad_out_ff;
    assign pad_oe         = pad_oe_ff;
    assign pad_pullup     = pad_pu_ff;
    assign pad_rx_en      = pad_rx_ff;
    assign pad_drive_high = drv_ff;
    assign per_in         = per_in_ff;
    assign dbg_in         = dbg_in_ff;
    assign ext_int_lvl    = ei_lvl_ff;
    assign ext_int_edge   = ei_edge_ff;
    assign conv_start     = conv_ff;
    assign ext_clk        = eclk_ff;

    // Whole words only, so hsize is unused
    logic unused_ok;
    assign unused_ok = ^hsize;
endmodule : pxb_port_io

// ---- core/pxb_xbar_map.sv ----
// Purpose: Priority decoder giving each crossbar pin its owning slot
// Assumes: Slot enables and skip bits are steady register outputs
// Notes:   Map is registered, so it trails a setting change by a cycle
`timescale 1ns/10ps
module pxb_xbar_map
    import pxb_pkg::*;
(
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic [SLOT_N-1:0]    slot_en,
    input  wire logic [XB_N-1:0]      skip,
    output logic [XB_N*OWN_W-1:0]     own_map
);
    logic [XB_N*OWN_W-1:0] own_map_ff;
    logic [XB_N*OWN_W-1:0] nxt_own_map;

    // Walk the slots by priority, each taking the lowest free pin
    always_comb begin
        logic [XB_N-1:0] taken;
        logic            found;
        taken = skip;
        found = 1'b0;
        nxt_own_map = {XB_N{OWN_NONE}};
        // Serial unit is pinned regardless of priority
        if (slot_en[SL_UTX]) begin
            nxt_own_map[PIN_UTX*OWN_W +: OWN_W] = OWN_W'(SL_UTX);
            nxt_own_map[PIN_URX*OWN_W +: OWN_W] = OWN_W'(SL_URX);
            taken[PIN_UTX] = 1'b1;
            taken[PIN_URX] = 1'b1;
        end
        for (int s = SL_SPI; s < SLOT_N; s++) begin
            found = 1'b0;
            for (int i = 0; i < XB_N; i++) begin
                if (slot_en[s] && !found && !taken[i]) begin
                    nxt_own_map[i*OWN_W +: OWN_W] = OWN_W'(s);
                    taken[i] = 1'b1;
                    found    = 1'b1;
                end
            end
        end
    end

    // Registered map
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_map_ff <= {XB_N{OWN_NONE}};
        end else begin
            own_map_ff <= nxt_own_map;
        end
    end

    assign own_map = own_map_ff;
endmodule : pxb_xbar_map

// ---- test/pxb_pad_model.sv ----
// Purpose: Board side of the pads, drivers and pull-ups
// Assumes: Pad controls come straight from the block
// Notes:   An undriven, unpulled pin toggles every cycle
`timescale 1ns/10ps
module pxb_pad_model
    import pxb_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [PIN_N-1:0] pad_out,
    input  wire logic [PIN_N-1:0] pad_oe,
    input  wire logic [PIN_N-1:0] pad_pullup,
    input  wire logic [PIN_N-1:0] ext_drv,
    input  wire logic [PIN_N-1:0] ext_val,
    output logic      [PIN_N-1:0] pad_in
);
    logic [PIN_N-1:0] float_ff;
    // Floating level keeps moving so it never looks settled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            float_ff <= 18'h00000;
        end else begin
            float_ff <= ~float_ff;
        end
    end
    // Block driver first, then board driver, then pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
                  | (~pad_oe & ~ext_drv & (pad_pullup | float_ff));
endmodule : pxb_pad_model

// ---- test/pxb_port_io_chk.sv ----
// Purpose: Port level assertions for the port I/O block
// Assumes: One hclk domain, async active low reset
// Notes:   Crossbar enable is shadowed from bus writes
`timescale 1ns/10ps
module pxb_port_io_chk
    import pxb_pkg::*;
(
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic [PIN_N-1:0] pad_oe,
    input wire logic [PIN_N-1:0] pad_pullup,
    input wire logic [PIN_N-1:0] pad_rx_en,
    input wire logic [2:0]       pad_drive_high,
    input wire logic [1:0]       ext_int_lvl,
    input wire logic [1:0]       ext_int_edge,
    input wire logic             conv_start,
    input wire logic             ext_clk
);
    logic       wr_ff;
    logic       xen_ff;
    logic [1:0] lvl_ff;
    logic [1:0] lvl2_ff;
    // Enable shadow, caught in the write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff  <= 1'b0;
            xen_ff <= 1'b0;
        end else begin
            wr_ff <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == REG_SEL_C);
            if (wr_ff) begin
                xen_ff <= hwdata[SC_CROSSBAR_ENABLE_BIT];
            end
        end
    end
    // Level history, the edge flag may trail the level a cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_ff  <= 2'h0;
            lvl2_ff <= 2'h0;
        end else begin
            lvl_ff  <= ext_int_lvl;
            lvl2_ff <= lvl_ff;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Two cycles off, since the pad stage is registered
    sequence s_xbar_off;
        !xen_ff ##1 !xen_ff;
    endsequence
    a_xbar_off_quiet: assert property (s_xbar_off |-> pad_oe[XB_N-1:0] == 16'h0000)
        else $error("pin driven, crossbar off");
    // Debug pin masked out, the debug link ignores the modes
    a_analog_off: assert property ((~pad_rx_en & (pad_oe | pad_pullup) & 18'h2ffff) == 18'h0)
        else $error("analog pin active");
    a_pullup_drive: assert property ((pad_oe & pad_pullup & 18'h2ffff) == 18'h0)
        else $error("pull-up on while pin driven");
    a_reset_state: assert property ($rose(hresetn) |->
        pad_rx_en == RST_MDIN && pad_drive_high == RST_DRV)
        else $error("bad reset state");
    a_edge_cause: assert property ((ext_int_edge &
        ~((ext_int_lvl ^ lvl_ff) | (lvl_ff ^ lvl2_ff))) == 2'h0)
        else $error("stray event pulse");
    a_edge_seen: assert property ($changed(ext_int_lvl[0]) |-> ##[0:1] ext_int_edge[0])
        else $error("missed event pulse");
    a_cnv_digital: assert property (conv_start |->
        pad_rx_en[PIN_CNV] || $past(pad_rx_en[PIN_CNV]))
        else $error("conversion start seen on analog pin");
    a_clk_digital: assert property (ext_clk |->
        pad_rx_en[PIN_CLK] || $past(pad_rx_en[PIN_CLK]))
        else $error("external clock seen on analog pin");
endmodule : pxb_port_io_chk

bind pxb_port_io pxb_port_io_chk u_chk (.*);

// ---- test/tb_port_io_crossbar.sv ----
// Purpose: Register level tests of the port I/O crossbar
// Assumes: Zero wait AHB-Lite slave, board model on pads
// Notes:   Waits follow the registered pad latencies
`timescale 1ns/10ps
module tb_port_io_crossbar;
    import pxb_pkg::*;
    logic              hclk = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel = 1'b0;
    logic              hwrite = 1'b0;
    logic [1:0]        htrans = 2'h0;
    logic [31:0]       haddr = 32'h0;
    logic [31:0]       hwdata = 32'h0;
    logic [SLOT_N-1:0] per_out = 20'hfffff;
    logic [SLOT_N-1:0] per_drv = 20'h00000;
    logic [PIN_N-1:0]  ext_drv = 18'h0;
    logic [PIN_N-1:0]  ext_val = 18'h0;
    logic              dbg_active = 1'b0;
    logic              dbg_out = 1'b0;
    logic              dbg_oe = 1'b0;
    logic              hreadyout, hresp, dbg_in, conv_start, ext_clk;
    logic [31:0]       hrdata, rd;
    logic [PIN_N-1:0]  pad_in, pad_out, pad_oe, pad_pullup, pad_rx_en, v;
    logic [2:0]        pad_drive_high;
    logic [SLOT_N-1:0] per_in;
    logic [1:0]        ext_int_lvl, ext_int_edge;
    int                n_fail = 0, num_checks = 0, cyc = 0, ne, k;
    // Reset table, last entry is an unmapped place
    logic [7:0]  ra [5] = '{REG_MDIN, REG_MDOUT, REG_SKIP, REG_DRV, 8'h24};
    logic [31:0] rv [5] = '{32'(RST_MDIN), 32'h0, 32'h0, 32'(RST_DRV), 32'h0};
    // GPIO steps: output mode, latch, select B, then enable and pull-up
    logic [17:0] gm [5] = '{18'h3ffff, 18'h3ffff, 18'h0, 18'h0, 18'h0};
    logic [17:0] gl [5] = '{18'h0, 18'h3ffff, 18'h3ffff, 18'h3ffff, 18'h0};
    logic [7:0]  gb [5] = '{8'h0, 8'h0, 8'h0, 8'h80, 8'h0};
    logic [17:0] go [5] = '{18'h3ffff, 18'h3ffff, 18'h0, 18'h0, 18'h3ffff};
    logic [17:0] gp [5] = '{18'h0, 18'h0, 18'h3ffff, 18'h0, 18'h0};

    pxb_port_io uut (.*, .hsize(3'h2), .hready(hreadyout));
    pxb_pad_model board (.*);

    always #25 hclk = ~hclk;
    // Ceiling well above test length
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : wt
    // Address phase held until hready, then data phase
    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= 1'b1; htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : ahb_wr
    task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= 1'b0; htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : ahb_rd
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wt(2);
        chk("rx_en", 32'(pad_rx_en), 32'h3ffff);
        chk("pullup", 32'(pad_pullup), 32'h3ffff);
        ahb_wr(8'h24, 32'hffffffff);
        for (k = 0; k < 5; k++) begin
            ahb_rd(ra[k], rd);
            chk("reset reg", rd, rv[k]);
        end
        chk("hresp", 32'(hresp), 32'h0);
        ahb_wr(REG_DRV, 32'h2);
        wt(1);
        chk("drive", 32'(pad_drive_high), 32'h2);
        $display("Test reset done");
        // Crossbar off: selections and latch must not reach pins
        ahb_wr(REG_MDOUT, 32'h3ffff);
        ahb_wr(REG_LATCH, 32'h0);
        ahb_wr(REG_SEL_A, 32'h1);
        ext_drv <= 18'h20; ext_val <= 18'h0;
        wt(5);
        chk("oe off", 32'(pad_oe[XB_N-1:0]), 32'h0);
        chk("per_in off", 32'(per_in), 32'hfffff);
        ext_drv <= 18'h0;
        ahb_wr(REG_SEL_A, 32'h0);
        ahb_wr(REG_SEL_C, 32'h1);
        for (k = 0; k < 5; k++) begin
            ahb_wr(REG_MDOUT, 32'(gm[k]));
            ahb_wr(REG_LATCH, 32'(gl[k]));
            ahb_wr(REG_SEL_B, 32'(gb[k]));
            wt(3);
            chk("gpio oe", 32'(pad_oe), 32'(go[k]));
            chk("gpio out", 32'(pad_out & pad_oe), 32'(gl[k] & go[k]));
            chk("gpio pullup", 32'(pad_pullup), 32'(gp[k]));
        end
        ahb_wr(REG_LATCH, 32'h3ffff);
        $display("Test gpio done");
        // Pins 3 and 6 high from the board, then made analog
        ext_drv <= 18'h48; ext_val <= 18'h48;
        wt(5);
        chk("fixed fns", 32'({conv_start, ext_clk}), 32'h3);
        ahb_wr(REG_SKIP, 32'h48);
        ahb_wr(REG_MDIN, 32'h3ffb7);
        wt(5);
        chk("rx_en", 32'(pad_rx_en), 32'h3ffb7);
        chk("analog pu", 32'(pad_pullup | pad_oe), 32'h3ffb7);
        chk("fixed analog", 32'({conv_start, ext_clk}), 32'h0);
        ahb_rd(REG_LATCH, rd);
        chk("latch analog", rd, 32'h3ffb7);
        ahb_wr(REG_MDIN, 32'h3ffff);
        ahb_wr(REG_SKIP, 32'h18);
        ext_drv <= 18'h3ffff; ext_val <= 18'h2a5c3;
        wt(5);
        ahb_rd(REG_LATCH, rd);
        chk("latch pins", rd, 32'h2a5c3);
        $display("Test analog done");
        // UART fixed even on skipped pin 4; SPI takes 0,1,2,6
        ahb_wr(REG_SEL_A, 32'h3);
        for (k = 0; k < 2; k++) begin
            v = k ? ~18'h25a56 : 18'h25a56;
            ext_val <= v;
            wt(5);
            chk("route", 32'(per_in), {12'h0, 14'h3fff, v[6], v[2], v[1], v[0], v[5], v[4]});
        end
        ext_drv <= 18'h0; per_drv <= 20'h4; per_out <= 20'hffffb;
        wt(3);
        chk("spi drive", 32'({pad_oe, pad_out[0]}), 32'h2);
        $display("Test routing done");
        // Two-wire pins stay open-drain in push-pull mode
        per_drv <= 20'h40; per_out <= 20'hfffff;
        ahb_wr(REG_SKIP, 32'h0);
        ahb_wr(REG_SEL_A, 32'h4);
        ahb_wr(REG_MDOUT, 32'h3ffff);
        wt(3);
        chk("sda high", 32'(pad_oe), 32'h3fffc);
        per_out <= 20'hfffbf;
        wt(3);
        chk("sda low", 32'({pad_oe, pad_out[0]}), 32'h7fffa);
        $display("Test two-wire done");
        ahb_wr(REG_MDOUT, 32'h0);
        ahb_wr(REG_EXTI, 32'h72);
        ext_drv <= 18'h4; ext_val <= 18'h0;
        wt(6);
        chk("int lvl", 32'(ext_int_lvl), 32'h2);
        ext_val <= 18'h4;
        ne = 0;
        for (k = 0; k < 6; k++) begin
            wt(1);
            if (ext_int_edge[0] === 1'b1) ne++;
        end
        chk("int edges", 32'(ne), 32'h1);
        chk("int lvl", 32'(ext_int_lvl), 32'h3);
        $display("Test event done");
        dbg_active <= 1'b1; dbg_oe <= 1'b1; ext_drv <= 18'h0;
        wt(3);
        chk("dbg drive", 32'({pad_oe[PIN_DBG], pad_out[PIN_DBG]}), 32'h2);
        dbg_oe <= 1'b0; ext_drv <= 18'h10000; ext_val <= 18'h10000;
        wt(5);
        chk("dbg in", 32'(dbg_in), 32'h1);
        $display("Test debug done");
        conclude();
    end
endmodule : tb_port_io_crossbar
